//--- tb/periph_model.sv
`timescale 1ns/10ps
module periph_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       data_strobe_n,
  input  wire logic       addr_strobe_n,
  input  wire logic       strobe_n,
  input  wire logic [7:0] pins_out,
  output logic            periph_wait_n,
  output logic [7:0]      drive_val,
  output logic [7:0]      last_addr,
  output logic [7:0]      last_data,
  output logic [7:0]      last_byte,
  output int              n_strobes
);
  logic as_q = 1'b1;
  logic ds_q = 1'b1;
  logic stb_q = 1'b1;
  initial begin
    periph_wait_n = 1'b0;
    drive_val = 8'h59;
    n_strobes = 0;
  end
  // Stall holds wait high so a new-variant cycle never starts
  always @(posedge clk) begin
    periph_wait_n <= stall | ~(data_strobe_n & addr_strobe_n);
    drive_val <= (data_strobe_n & addr_strobe_n) ? 8'h59 : 8'ha6;
    as_q <= addr_strobe_n;
    ds_q <= data_strobe_n;
    stb_q <= strobe_n;
    if (as_q && !addr_strobe_n)
      last_addr <= pins_out;
    // Write direction also lowers the printer strobe, so EPP data waits for the data strobe
    if (ds_q && !data_strobe_n && !strobe_n)
      last_data <= pins_out;
    if (stb_q && !strobe_n) begin
      last_byte <= pins_out;
      n_strobes <= n_strobes + 1;
    end
  end
endmodule // periph_model

//--- tb/tb_parallel_port_epp_ecp_control.sv
`timescale 1ns/10ps
module tb_parallel_port_epp_ecp_control;
  import ppc_pkg::*;
  logic core_clk = 0, rstn = 0, io_rd = 0, io_wr = 0, stall = 0;
  logic [10:0] io_addr = 11'h000;
  logic [7:0]  io_wdata = 8'h00, io_rdata, port_data_out, drive_val, last_addr, last_data, rd;
  logic        io_rvalid, io_ready, port_data_oe, strobe_out_n, autofeed_n, select_in_n;
  logic        periph_restart_n, busy_in, irq_req, seen;
  logic [7:0]  last_byte;
  logic [3:0]  sts = 4'h5;
  int          n_errors = 0, tests_run = 0, n_strobes, base;
  wire logic [7:0] port_data_in = port_data_oe ? port_data_out : drive_val;
  always #12.5 core_clk = ~core_clk;
  parallel_port_epp_ecp_control dut (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .io_ready(io_ready), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe), .strobe_out_n(strobe_out_n),
    .autofeed_n(autofeed_n), .periph_restart_n(periph_restart_n), .select_in_n(select_in_n),
    .peripheral_ack_n(sts[3]), .busy_in(busy_in), .media_error_in(sts[2]),
    .selected_in(sts[1]), .fault_in_n(sts[0]), .irq_req(irq_req));
  periph_model model (.clk(core_clk), .stall(stall), .data_strobe_n(autofeed_n),
    .addr_strobe_n(select_in_n), .strobe_n(strobe_out_n), .pins_out(port_data_out),
    .periph_wait_n(busy_in), .drive_val(drive_val), .last_addr(last_addr),
    .last_data(last_data), .last_byte(last_byte), .n_strobes(n_strobes));
  task automatic test_done;
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Requests go out after an edge and drop after the taking edge
  task automatic access(input logic [10:0] a, input logic [7:0] d, input logic r);
    int i;
    i = 0;
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_rd <= r;
    io_wr <= ~r;
    @(posedge core_clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    do @(negedge core_clk);
    while ((r ? io_rvalid : io_ready) !== 1'b1 && i++ < 600);
    if (i > 600) n_errors++;
    // Registered pins follow a taken write one edge later
    @(negedge core_clk);
    rd = io_rdata;
  endtask
  task automatic rdchk(input string what, input logic [10:0] a, input logic [7:0] exp);
    access(a, 8'h00, 1'b1);
    chk(what, exp, rd);
  endtask
  initial begin
    #500000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rdchk("control", OFS_CONTROL, 8'hc4);
    rdchk("ecr", OFS_ECR, 8'h15);
    rdchk("status", OFS_STATUS, 8'haf);
    access(OFS_CONTROL, 8'h3f, 1'b0);
    rdchk("control", OFS_CONTROL, 8'hff);
    chk("pins", 8'h01, {4'h0, strobe_out_n, autofeed_n, select_in_n, periph_restart_n});
    chk("oe", 8'h01, {7'h0, port_data_oe});
    access(OFS_DATA, 8'h5a, 1'b0);
    chk("data out", 8'h5a, port_data_out);
    access(OFS_CONTROL, 8'h20, 1'b0);
    chk("pins", 8'h0e, {4'h0, strobe_out_n, autofeed_n, select_in_n, periph_restart_n});
    access(OFS_ECR, 8'h20, 1'b0);
    chk("oe", 8'h00, {7'h0, port_data_oe});
    rdchk("data in", OFS_DATA, 8'h59);
    access(OFS_CONTROL, 8'h10, 1'b0);
    @(posedge core_clk);
    sts <= 4'hd;
    seen = 1'b0;
    repeat (4) @(negedge core_clk) seen |= irq_req;
    chk("irq", 8'h01, {7'h0, seen});
    rdchk("status", OFS_STATUS, 8'hef);
    access(OFS_ECR, 8'h80, 1'b0);
    access(OFS_EPP_ADDR, 8'h3c, 1'b0);
    chk("epp addr", 8'h3c, last_addr);
    access(11'h004, 8'hc3, 1'b0);
    chk("epp data", 8'hc3, last_data);
    rdchk("epp read", 11'h004, 8'ha6);
    rdchk("status", OFS_STATUS, 8'hee);
    stall <= 1'b1;
    access(11'h005, 8'h11, 1'b0);
    stall <= 1'b0;
    chk("no strobe", 8'hc3, last_data);
    rdchk("status", OFS_STATUS, 8'hef);
    access(OFS_STATUS, 8'h00, 1'b0);
    rdchk("status", OFS_STATUS, 8'hef);
    access(OFS_STATUS, 8'h01, 1'b0);
    rdchk("status", OFS_STATUS, 8'hee);
    for (int m = 0; m < 8; m++) begin
      access(OFS_ECR, {m[2:0], 5'h00}, 1'b0);
      access(OFS_ECR, 8'h00, 1'b1);
      chk("mode", {5'h0, m[2:0]}, {5'h0, rd[7:5]});
    end
    access(OFS_ECR, 8'hc0, 1'b0);
    access(OFS_FIFO, 8'h9d, 1'b0);
    rdchk("test fifo", OFS_FIFO, 8'h9d);
    stall <= 1'b1;
    access(OFS_ECR, 8'h40, 1'b0);
    base = n_strobes;
    for (int i = 0; i < 18; i++)
      access(OFS_FIFO, i[7:0], 1'b0);
    access(OFS_ECR, 8'h00, 1'b1);
    chk("full", 8'h02, {6'h0, rd[1:0]});
    stall <= 1'b0;
    for (int k = 0; k < 1000 && rd[0] !== 1'b1; k++)
      access(OFS_ECR, 8'h00, 1'b1);
    repeat (60) @(posedge core_clk);
    chk("sent", 8'd17, 8'(n_strobes - base));
    chk("last byte", 8'h10, last_byte);
    stall <= 1'b1;
    access(OFS_FIFO, 8'h77, 1'b0);
    access(OFS_FIFO, 8'h78, 1'b0);
    access(OFS_ECR, 8'h00, 1'b0);
    stall <= 1'b0;
    access(OFS_ECR, 8'h00, 1'b1);
    chk("flush", 8'h01, {6'h0, rd[1:0]});
    test_done;
  end
endmodule // tb_parallel_port_epp_ecp_control

//--- verilog/parallel_port_epp_ecp_control.sv
// Function
// - Data strobe low marks EPP data cycles; write-direction low writes, high reads.
// - Address strobe low instead of data strobe marks EPP address cycles.
// - Restart line held low returns the peripheral to its initial mode.
// - Outside EPP cycles and buffer transfers, pins follow control bits and direction bit.
// - EPP cycle not finished within 10 us aborts and sets status bit 0.
// - EPP address cycles and data reads and writes run independently, in any order.
// - Newer variant: cycle started with wait low ends when wait goes high.
// - Newer variant: no cycle starts while wait high; start when it drops.
// - Older variant: start regardless, finish on wait low-to-high transition.
// - One 16-byte buffer serves ECP both directions and compatibility FIFO.
// - Received run-length byte repeats the next received byte that many times.
// - Extended control bits 7-5 select one of eight operating modes.
// - Modes 000/001: write latches data onto pins; read returns pins.
// - Mode 011 forward: offset zero write enters buffer tagged as address/run-length.
// - Status bit 7 is inverted busy; bits 6-3 reflect ack, paper, select, fault.
// - Status bits 2-1 read as ones; bit 0 also reads as one outside mode 100.
// - Control bits 7-6 read as ones and ignore writes.
// - Control bit 5 sets input direction except modes 000, 010 and 101.
// - With control bit 4 set, ack rising edge raises an interrupt request.
// - Control bit 2 drives init uninverted; bits 3,1,0 drive outputs inverted.
// - Mode 010 sends buffered bytes forward with strobe/busy handshake.
// - Writing one to time-out status clears it; zero leaves it.
// - Mode 000 holds the buffer reset and empty.
`timescale 1ns/10ps

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("byte_fifo depth must be a power of two");
    end
  endgenerate

  assign in_ready  = (wptr - rptr) != (AW + 1)'(DEPTH);
  assign out_valid = wptr != rptr;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else if (clear) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready && !clear) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
endmodule // byte_fifo

module parallel_port_epp_ecp_control
  import ppc_pkg::*;
#(
  parameter bit EPP_ENABLE  = 1'b1,
  parameter bit EPP_V19     = 1'b1,
  parameter int FIFO_DEPTHS = FIFO_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [10:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  output logic             io_rvalid,
  output logic             io_ready,
  input  wire logic [7:0]  port_data_in,
  output logic [7:0]       port_data_out,
  output logic             port_data_oe,
  output logic             strobe_out_n,
  output logic             autofeed_n,
  output logic             periph_restart_n,
  output logic             select_in_n,
  input  wire logic        peripheral_ack_n,
  input  wire logic        busy_in,
  input  wire logic        media_error_in,
  input  wire logic        selected_in,
  input  wire logic        fault_in_n,
  output logic             irq_req
);
  generate
    if (FIFO_DEPTHS != FIFO_DEPTH) begin : g_bad_fifo
      $error("buffer depth is fixed at 16 bytes");
    end
  endgenerate

  typedef enum logic [2:0] {
    EP_IDLE   = 3'b001,
    EP_WAIT   = 3'b010,
    EP_STROBE = 3'b100
  } epp_state_type;

  typedef enum logic [5:0] {
    XF_IDLE     = 6'b000001,
    XF_SETUP    = 6'b000010,
    XF_STROBE   = 6'b000100,
    XF_HOLD     = 6'b001000,
    XF_REV_WAIT = 6'b010000,
    XF_REV_ACK  = 6'b100000
  } xfer_state_type;

  logic [7:0]     data_latch;
  logic [5:0]     dcr;
  logic [2:0]     cur_mode;
  logic [2:0]     ecr_ctl;
  logic [2:0]     cfgb;
  logic           cycle_timeout_flag;
  logic           ack_prev;
  epp_state_type  epp_state;
  logic           epp_is_addr;
  logic           epp_is_write;
  logic [7:0]     epp_wdata;
  logic [15:0]    epp_timer;
  logic           wait_seen_low;
  xfer_state_type xf_state;
  fifo_word_type  xf_word;
  logic [7:0]     xf_timer;
  fifo_word_type  rev_word;
  logic [6:0]     rle_count;
  logic [7:0]     rep_left;
  fifo_word_type  fifo_in;
  fifo_word_type  fifo_out;
  logic           fifo_in_valid;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic           fifo_out_ready;
  logic           fifo_clear;
  logic           epp_busy;
  logic           host_rd;
  logic           host_wr;
  logic           epp_start;
  logic           epp_done;
  logic           epp_abort;
  logic           epp_finish;
  logic           dir_eff;
  logic           fwd_mode;
  logic           rev_mode;
  logic           ecp_fwd;
  logic           host_push;
  logic           host_pop;
  logic           xf_take;
  logic           write_direction_n;
  logic           data_strobe_n;
  logic           addr_strobe_n;
  logic [7:0]     next_data_out;
  logic           next_oe;
  logic           next_strobe_n;
  logic           next_autofeed_n;
  logic           next_select_in_n;
  logic           periph_wait_n;

  // The wait handshake shares the busy pin while in EPP mode
  assign periph_wait_n = busy_in;
  assign epp_busy      = epp_state != EP_IDLE;
  assign host_rd       = io_rd && !epp_busy;
  assign host_wr       = io_wr && !epp_busy;
  assign epp_start     = (host_rd || host_wr) && EPP_ENABLE && cur_mode == MODE_EPP
                         && io_addr >= OFS_EPP_ADDR && io_addr <= OFS_EPP_LAST;
  assign epp_done      = epp_state == EP_STROBE && periph_wait_n && wait_seen_low;
  assign epp_abort     = epp_busy && !epp_done && epp_timer == 16'(TIMEOUT_CYC - 1);
  assign epp_finish    = epp_done || epp_abort;
  assign dir_eff       = dcr[DCR_DIR] && !(cur_mode == MODE_COMPAT || cur_mode == MODE_COMPAT_FIFO_PORT
                         || cur_mode == MODE_RSVD);
  assign ecp_fwd       = cur_mode == MODE_ECP && !dcr[DCR_DIR];
  assign fwd_mode      = cur_mode == MODE_COMPAT_FIFO_PORT || ecp_fwd;
  assign rev_mode      = cur_mode == MODE_ECP && dcr[DCR_DIR];
  assign fifo_clear    = cur_mode == MODE_COMPAT || cur_mode == MODE_RSVD;

  // Host bytes into the shared buffer; address/run-length bytes carry the tag
  assign host_push = host_wr && ((io_addr == OFS_FIFO && (cur_mode == MODE_COMPAT_FIFO_PORT
                     || cur_mode == MODE_TEST || ecp_fwd))
                     || (io_addr == OFS_DATA && ecp_fwd));
  assign host_pop  = host_rd && io_addr == OFS_FIFO && (cur_mode == MODE_TEST || rev_mode);
  assign xf_take   = xf_state == XF_IDLE && fwd_mode && fifo_out_valid;
  assign fifo_out_ready = host_pop || xf_take;

  // A full buffer drops host bytes; software must watch the full flag
  always_comb begin
    if (rev_mode) begin
      fifo_in_valid = rep_left != 8'h00;
      fifo_in       = rev_word;
    end else begin
      fifo_in_valid = host_push;
      fifo_in.tag   = io_addr == OFS_DATA;
      fifo_in.data  = io_wdata;
    end
  end

  byte_fifo #(
    .WIDTH ($bits(fifo_word_type)),
    .DEPTH (FIFO_DEPTHS)
  ) u_fifo (
    .clk       (core_clk),
    .rstn      (rstn),
    .clear     (fifo_clear),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_latch <= DATA_RESET;
      dcr        <= DCR_RESET;
      cur_mode   <= ECR_MODE_RESET;
      ecr_ctl    <= ECR_CTL_RESET;
      cfgb       <= CFGB_RESET;
    end else if (host_wr) begin
      if (io_addr == OFS_DATA && cur_mode != MODE_ECP) begin
        data_latch <= io_wdata;
      end
      if (io_addr == OFS_CONTROL) begin
        dcr <= io_wdata[5:0];
      end
      if (io_addr == OFS_ECR) begin
        cur_mode <= io_wdata[ECR_MODE_LSB +: 3];
        ecr_ctl  <= io_wdata[ECR_CTL_LSB +: 3];
      end
      if (io_addr == OFS_CFGB && cur_mode == MODE_CONFIG) begin
        cfgb <= io_wdata[CFGB_IRQ_LSB +: 3];
      end
    end
  end

  // A fresh abort beats a clear written in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cycle_timeout_flag <= 1'b0;
    end else if (epp_abort) begin
      cycle_timeout_flag <= 1'b1;
    end else if (host_wr && io_addr == OFS_STATUS && io_wdata[STS_CYCLE_TIMEOUT_FLAG]) begin
      cycle_timeout_flag <= 1'b0;
    end
  end

  // Address and data cycles are independent; the peripheral keeps the selection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      epp_state     <= EP_IDLE;
      epp_is_addr   <= 1'b0;
      epp_is_write  <= 1'b0;
      epp_wdata     <= 8'h00;
      epp_timer     <= 16'h0000;
      wait_seen_low <= 1'b0;
      io_ready      <= 1'b1;
    end else begin
      unique case (epp_state)
        EP_IDLE: begin
          if (epp_start) begin
            epp_is_addr   <= io_addr == OFS_EPP_ADDR;
            epp_is_write  <= host_wr;
            epp_wdata     <= io_wdata;
            epp_timer     <= 16'h0000;
            wait_seen_low <= 1'b0;
            io_ready      <= 1'b0;
            epp_state     <= EPP_V19 ? EP_WAIT : EP_STROBE;
          end
        end
        EP_WAIT: begin
          // Back to zero on abort so the count never passes the limit
          epp_timer <= epp_finish ? 16'h0000 : epp_timer + 16'h0001;
          if (epp_abort) begin
            epp_state <= EP_IDLE;
            io_ready  <= 1'b1;
          end else if (!periph_wait_n) begin
            wait_seen_low <= 1'b1;
            epp_state     <= EP_STROBE;
          end
        end
        EP_STROBE: begin
          epp_timer <= epp_finish ? 16'h0000 : epp_timer + 16'h0001;
          if (!periph_wait_n) begin
            wait_seen_low <= 1'b1;
          end
          if (epp_finish) begin
            epp_state <= EP_IDLE;
            io_ready  <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata  <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= 1'b0;
      if (epp_finish && !epp_is_write) begin
        io_rdata  <= port_data_in;
        io_rvalid <= 1'b1;
      end else if (host_rd && !epp_start) begin
        io_rvalid <= 1'b1;
        unique case (io_addr)
          OFS_DATA:    io_rdata <= cur_mode == MODE_ECP ? UNMAPPED_VALUE : port_data_in;
          OFS_STATUS:  io_rdata <= {~busy_in, peripheral_ack_n, media_error_in, selected_in,
                                    fault_in_n, STS_ONES[2:1],
                                    cur_mode == MODE_EPP ? cycle_timeout_flag : STS_ONES[0]};
          OFS_CONTROL: io_rdata <= {DCR_ONES, dcr};
          OFS_FIFO: begin
            if (cur_mode == MODE_CONFIG) begin
              io_rdata <= CONFIG_A_VALUE;
            end else if (host_pop && fifo_out_valid) begin
              io_rdata <= fifo_out.data;
            end else begin
              io_rdata <= UNMAPPED_VALUE;
            end
          end
          OFS_CFGB:    io_rdata <= cur_mode == MODE_CONFIG ? {1'b0, irq_req, cfgb, STS_ONES}
                                   : UNMAPPED_VALUE;
          OFS_ECR:     io_rdata <= {cur_mode, ecr_ctl, ~fifo_in_ready, ~fifo_out_valid};
          default:     io_rdata <= UNMAPPED_VALUE;
        endcase
      end
    end
  end

  // Automatic transfers: forward strobe/busy or ECP, reverse ECP with run-length expansion
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xf_state  <= XF_IDLE;
      xf_word   <= '0;
      xf_timer  <= 8'h00;
      rev_word  <= '0;
      rle_count <= 7'h00;
      rep_left  <= 8'h00;
    end else if (!(fwd_mode || rev_mode)) begin
      xf_state  <= XF_IDLE;
      rep_left  <= 8'h00;
      rle_count <= 7'h00;
    end else begin
      if (fifo_in_valid && fifo_in_ready) begin
        rep_left <= rep_left - 8'h01;
      end
      unique case (xf_state)
        XF_IDLE: begin
          xf_timer <= 8'h00;
          if (xf_take) begin
            xf_word  <= fifo_out;
            xf_state <= XF_SETUP;
          end else if (rev_mode) begin
            xf_state <= XF_REV_WAIT;
          end
        end
        XF_SETUP: begin
          if (xf_timer != 8'(SETUP_CYC - 1)) begin
            xf_timer <= xf_timer + 8'h01;
          end else if (!busy_in) begin
            xf_timer <= 8'h00;
            xf_state <= XF_STROBE;
          end
        end
        XF_STROBE: begin
          xf_timer <= xf_timer + 8'h01;
          if (ecp_fwd ? busy_in : xf_timer == 8'(STROBE_CYC - 1)) begin
            xf_timer <= 8'h00;
            xf_state <= XF_HOLD;
          end
        end
        XF_HOLD: begin
          xf_timer <= xf_timer + 8'h01;
          if (ecp_fwd ? !busy_in : xf_timer == 8'(SETUP_CYC - 1)) begin
            xf_state <= XF_IDLE;
          end
        end
        XF_REV_WAIT: begin
          if (!rev_mode) begin
            xf_state <= XF_IDLE;
          end else if (!peripheral_ack_n) begin
            xf_state <= XF_REV_ACK;
            if (busy_in) begin
              rev_word  <= '{tag: 1'b0, data: port_data_in};
              rep_left  <= {1'b0, rle_count} + 8'h01;
              rle_count <= 7'h00;
            end else if (!port_data_in[7]) begin
              rle_count <= port_data_in[6:0];
            end else begin
              rev_word <= '{tag: 1'b1, data: port_data_in};
              rep_left <= 8'h01;
            end
          end
        end
        XF_REV_ACK: begin
          // Holding the ack phase until the repeats are stored stalls the peripheral
          if (peripheral_ack_n && rep_left == 8'h00) begin
            xf_state <= XF_REV_WAIT;
          end
        end
      endcase
    end
  end

  always_comb begin
    write_direction_n = !epp_is_write;
    data_strobe_n     = !(epp_state == EP_STROBE && !epp_is_addr);
    addr_strobe_n     = !(epp_state == EP_STROBE && epp_is_addr);
    next_data_out     = data_latch;
    next_oe           = !dir_eff;
    next_strobe_n     = ~dcr[DCR_STB];
    next_autofeed_n   = ~dcr[DCR_AFD];
    next_select_in_n  = ~dcr[DCR_SELECT_IN_N];
    if (epp_busy) begin
      next_data_out    = epp_wdata;
      next_oe          = epp_is_write;
      next_strobe_n    = write_direction_n;
      next_autofeed_n  = data_strobe_n;
      next_select_in_n = addr_strobe_n;
    end else if (xf_state == XF_SETUP || xf_state == XF_STROBE || xf_state == XF_HOLD) begin
      next_data_out = xf_word.data;
      next_oe       = 1'b1;
      next_strobe_n = xf_state != XF_STROBE;
      if (ecp_fwd) begin
        next_autofeed_n = !xf_word.tag;
      end
    // The reverse state lingers one cycle after a mode change, longer from XF_REV_ACK into a forward mode; lines follow the control bits then
    end else if (rev_mode && (xf_state == XF_REV_WAIT || xf_state == XF_REV_ACK)) begin
      next_oe         = 1'b0;
      next_autofeed_n = xf_state == XF_REV_ACK;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port_data_out    <= DATA_RESET;
      port_data_oe     <= 1'b1;
      strobe_out_n     <= 1'b1;
      autofeed_n       <= 1'b1;
      select_in_n      <= 1'b1;
      periph_restart_n <= DCR_RESET[DCR_INIT];
      ack_prev         <= 1'b1;
      irq_req          <= 1'b0;
    end else begin
      port_data_out    <= next_data_out;
      port_data_oe     <= next_oe;
      strobe_out_n     <= next_strobe_n;
      autofeed_n       <= next_autofeed_n;
      select_in_n      <= next_select_in_n;
      periph_restart_n <= dcr[DCR_INIT];
      ack_prev         <= peripheral_ack_n;
      irq_req          <= dcr[DCR_ACKIE] && !ack_prev && peripheral_ack_n;
    end
  end

  a_strobe_excl: assert property (@(posedge core_clk) disable iff (!rstn)
    !(data_strobe_n == 1'b0 && addr_strobe_n == 1'b0))
    else $error("address and data strobes both active");
  a_timeout_set: assert property (@(posedge core_clk) disable iff (!rstn)
    epp_abort |=> cycle_timeout_flag && epp_state == EP_IDLE && io_ready)
    else $error("timeout did not abort the cycle and set the flag");
  a_timer_bound: assert property (@(posedge core_clk) disable iff (!rstn)
    epp_timer <= 16'(TIMEOUT_CYC - 1))
    else $error("cycle timer ran past the limit");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    host_wr && io_addr == OFS_STATUS && io_wdata[0] && !epp_abort |=> !cycle_timeout_flag)
    else $error("time-out flag not cleared by writing one");
  a_fifo_reset: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_mode == MODE_COMPAT |=> !fifo_out_valid)
    else $error("buffer not empty in compatible mode");
  a_status_ones: assert property (@(posedge core_clk) disable iff (!rstn)
    host_rd && io_addr == OFS_STATUS && cur_mode != MODE_EPP
    |=> io_rvalid && io_rdata[2:0] == 3'b111)
    else $error("status low bits not ones");
  a_control_ones: assert property (@(posedge core_clk) disable iff (!rstn)
    host_rd && io_addr == OFS_CONTROL && !epp_start |=> io_rdata[7:6] == 2'b11)
    else $error("control high bits not ones");
  a_dir_forced: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_mode == MODE_COMPAT && !epp_busy |=> port_data_oe)
    else $error("data lines not driven in compatible mode");
  a_v19_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    epp_state == EP_WAIT && periph_wait_n && !epp_abort
    |=> ##1 autofeed_n && select_in_n)
    else $error("strobe asserted while wait high");
  a_restart_map: assert property (@(posedge core_clk) disable iff (!rstn)
    ##1 periph_restart_n == $past(dcr[DCR_INIT]))
    else $error("init output does not follow control bit 2");
  a_ack_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    dcr[DCR_ACKIE] && $rose(peripheral_ack_n) |-> ##1 irq_req)
    else $error("ack rising edge raised no request");
endmodule // parallel_port_epp_ecp_control

//--- verilog/ppc_pkg.sv
package ppc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEOUT_NS    = 10000;
  localparam int TIMEOUT_CYC   = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS     = 500;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS      = 500;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH    = 16;
  localparam int DATA_W        = 8;

  localparam logic [10:0] OFS_DATA     = 11'h000;
  localparam logic [10:0] OFS_STATUS   = 11'h001;
  localparam logic [10:0] OFS_CONTROL  = 11'h002;
  localparam logic [10:0] OFS_EPP_ADDR = 11'h003;
  localparam logic [10:0] OFS_EPP_LAST = 11'h007;
  localparam logic [10:0] OFS_FIFO     = 11'h400;
  localparam logic [10:0] OFS_CFGB     = 11'h401;
  localparam logic [10:0] OFS_ECR      = 11'h402;

  localparam logic [2:0] MODE_COMPAT = 3'h0;
  localparam logic [2:0] MODE_BIDIR  = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO_PORT  = 3'h2;
  localparam logic [2:0] MODE_ECP    = 3'h3;
  localparam logic [2:0] MODE_EPP    = 3'h4;
  localparam logic [2:0] MODE_RSVD   = 3'h5;
  localparam logic [2:0] MODE_TEST   = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;

  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_CTL_LSB  = 2;
  localparam int DCR_DIR      = 5;
  localparam int DCR_ACKIE    = 4;
  localparam int DCR_SELECT_IN_N     = 3;
  localparam int DCR_INIT     = 2;
  localparam int DCR_AFD      = 1;
  localparam int DCR_STB      = 0;
  localparam int STS_CYCLE_TIMEOUT_FLAG    = 0;
  localparam int CFGB_IRQ_LSB = 3;

  localparam logic [5:0] DCR_RESET      = 6'h04;
  localparam logic [2:0] ECR_MODE_RESET = 3'h0;
  localparam logic [2:0] ECR_CTL_RESET  = 3'h5;
  localparam logic [2:0] CFGB_RESET     = 3'h0;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
  localparam logic [2:0] STS_ONES       = 3'h7;
  localparam logic [1:0] DCR_ONES       = 2'h3;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  typedef struct packed {
    logic       tag;
    logic [7:0] data;
  } fifo_word_type;
endpackage
